// ### ext_osc_model.sv
// Behavioural external oscillator for the clock control bench.
// Assumes a fast system clock; the output toggles every HALF cycles while run is high.
`timescale 1ns/10ps
`default_nettype none

module ext_osc_model #(
  parameter int HALF = 2
) (
  // Clock.
  input wire logic sys_clk,
  // Control; low models a dead oscillator.
  input wire logic run,
  // Oscillator output.
  output wire logic extClk
);
  logic lvl = 1'h1;
  int cnt = 0;
  assign extClk = lvl;
  // A dead oscillator stops high, so no falling edge ever reaches the detector.
  always @(posedge sys_clk) begin
    if (!run) begin
      cnt <= 0;
      lvl <= 1'h1;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      lvl <= ~lvl;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : ext_osc_model

`default_nettype wire

// ### osc_fail_monitor_pkg.sv
// Types shared by the clock control block.
// Assumes the constants header is compiled alongside.
package osc_fail_monitor_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_COUNT = 2'h1,
    ST_SWAP = 2'h3
  } startupState_t;

  typedef struct packed {
    logic [2:0] currentClkSelect;
    logic [3:0] currentDivider;
    logic [3:0] hfFreqSelect;
    logic failSafe;
    logic startupBusy;
    logic lowFreqEnable;
    logic converterRcEnable;
  } clkState_t;

endpackage : osc_fail_monitor_pkg

// ### osc_fail_monitor_regs.svh
// Register offsets, field positions, reset values and counts for the clock control block.
// Assumes a 32-bit AXI4-Lite bus with one aligned word per register.
`ifndef OSC_FAIL_MONITOR_REGS_SVH
`define OSC_FAIL_MONITOR_REGS_SVH

`define TRIM_OFS 8'h00
`define CTRL_OFS 8'h04
`define STAT_OFS 8'h08
`define FORCE_OFS 8'h0C
`define INT_STAT_OFS 8'h10
`define INT_CLR_OFS 8'h14
`define INT_EN_OFS 8'h18

`define TRIM_RST 6'h00
`define SEL_LSB 0
`define DIV_LSB 4
`define FRQ_LSB 8
`define ST_FAILSAFE 8
`define ST_TIMER 9
`define ST_LF_EN 10
`define ST_CONV_EN 11
`define FORCE_CONV_ON 0
`define FORCE_CONV_SEL 1
`define INT_FAIL_BIT 0

`define SEL_HF_INT 3'h6
`define SEL_LF_INT 3'h5
`define SEL_EXT_PLL 3'h2
`define SEL_SECONDARY 3'h4
`define SEL_EXT 3'h7
`define DIV_RST 4'h0
`define FRQ_RST 4'h0

`define SAMPLE_DIV 64
`define OST_EDGES 1024

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### osc_tune_and_fail_safe_monitor.sv
// Clock source control: oscillator trim, oscillator enables and fail-safe clock monitor.
// Assumes extClk and lowFreqInternalClk arrive already synchronous to sys_clk,
// and that sys_clk runs much faster than either of them.
`timescale 1ns/10ps
`include "osc_fail_monitor_regs.svh"
`default_nettype none

module osc_tune_and_fail_safe_monitor
  import osc_fail_monitor_pkg::*;
#(
  parameter int unsigned SAMPLE_DIV = `SAMPLE_DIV,
  parameter int unsigned OST_COUNT = `OST_EDGES
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_b,
  // AXI4-Lite write channels.
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels.
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Configuration straps and core events.
  input wire logic monitorEnableCfg,
  input wire logic [2:0] resetClkSelectCfg,
  input wire logic sleepExec,
  // Clock inputs sampled as levels.
  input wire logic extClk,
  input wire logic lowFreqInternalClk,
  // Outputs.
  output logic [5:0] oscTrimValue,
  output clkState_t clkState,
  output logic irq
);

  localparam int unsigned HALF_DIV = SAMPLE_DIV / 2;
  localparam logic [15:0] HALF_LAST = 16'(HALF_DIV - 1);
  localparam logic [15:0] OST_LAST = 16'(OST_COUNT - 1);

  function automatic logic isExternal(input logic [2:0] sel);
    return (sel == `SEL_EXT) || (sel == `SEL_EXT_PLL) || (sel == `SEL_SECONDARY);
  endfunction : isExternal

  // Bus slave state.
  logic awHeld_r;
  logic [7:0] awAddr_r;
  logic wHeld_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic doWrite;
  logic doRead;
  logic wrHit;
  logic [31:0] readWord;
  logic readHit;

  // Control state.
  logic started_r;
  logic [2:0] resetSel_r;
  logic [5:0] trim_r;
  logic [2:0] newSel_r;
  logic [3:0] newDiv_r;
  logic [3:0] freq_r;
  logic [2:0] curSel_r;
  logic [3:0] curDiv_r;
  logic failSafe_r;
  logic convForce_r;
  logic convSelRc_r;
  logic failFlag_r;
  logic failIntEn_r;
  startupState_t ostState_r;
  logic [15:0] ostCnt_r;

  // Monitor state.
  logic lfPrev_r;
  logic extPrev_r;
  logic [15:0] divCnt_r;
  logic sampleClk_r;
  logic detLatch_r;
  logic armed_r;
  logic lfRise;
  logic extFall;
  logic sampleRise;
  logic sampleFall;
  logic monActive;
  logic failDet;

  logic ctrlWrite;
  logic [31:0] ctrlWord;

  assign awready = !awHeld_r && !bvalid_r;
  assign wready = !wHeld_r && !bvalid_r;
  assign arready = !rvalid_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign doWrite = awHeld_r && wHeld_r && !bvalid_r;
  assign doRead = arvalid && !rvalid_r;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      awHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
    end else if (awvalid && awready) begin
      awHeld_r <= 1'b1;
      awAddr_r <= awaddr[7:0];
    end else if (doWrite) begin
      awHeld_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wHeld_r <= 1'b0;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
    end else if (wvalid && wready) begin
      wHeld_r <= 1'b1;
      wData_r <= wdata;
      wStrb_r <= wstrb;
    end else if (doWrite) begin
      wHeld_r <= 1'b0;
    end
  end

  always_comb begin
    case (awAddr_r)
      `TRIM_OFS, `CTRL_OFS, `STAT_OFS, `FORCE_OFS,
      `INT_STAT_OFS, `INT_CLR_OFS, `INT_EN_OFS: wrHit = 1'b1;
      default: wrHit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else if (doWrite) begin
      bvalid_r <= 1'b1;
      bresp_r <= wrHit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_comb begin
    readWord = 32'h0000_0000;
    readHit = 1'b1;
    case (araddr[7:0])
      `TRIM_OFS: readWord[5:0] = trim_r;
      `CTRL_OFS: readWord = ctrlWord;
      `STAT_OFS: begin
        readWord[`SEL_LSB +: 3] = curSel_r;
        readWord[`DIV_LSB +: 4] = curDiv_r;
        readWord[`ST_FAILSAFE] = failSafe_r;
        readWord[`ST_TIMER] = clkState.startupBusy;
        readWord[`ST_LF_EN] = clkState.lowFreqEnable;
        readWord[`ST_CONV_EN] = clkState.converterRcEnable;
      end
      `FORCE_OFS: begin
        readWord[`FORCE_CONV_ON] = convForce_r;
        readWord[`FORCE_CONV_SEL] = convSelRc_r;
      end
      `INT_STAT_OFS: readWord[`INT_FAIL_BIT] = failFlag_r;
      `INT_CLR_OFS: readWord = 32'h0000_0000;
      `INT_EN_OFS: readWord[`INT_FAIL_BIT] = failIntEn_r;
      default: readHit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `RESP_OKAY;
    end else if (doRead) begin
      rvalid_r <= 1'b1;
      rdata_r <= readWord;
      rresp_r <= readHit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // The resetClkSelectCfg strap is caught on the first edge after reset release, never by the reset itself.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      started_r <= 1'b0;
      resetSel_r <= `SEL_HF_INT;
    end else if (!started_r) begin
      started_r <= 1'b1;
      resetSel_r <= resetClkSelectCfg;
    end
  end

  // The trim only drives the high-frequency oscillator; apart from the TRIM_OFS read-back nothing else in this block reads it.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      trim_r <= `TRIM_RST;
    end else if (doWrite && awAddr_r == `TRIM_OFS && wStrb_r[0]) begin
      trim_r <= wData_r[5:0];
    end
  end
  assign oscTrimValue = trim_r;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      convForce_r <= 1'b0;
      convSelRc_r <= 1'b0;
      failIntEn_r <= 1'b0;
    end else if (doWrite && awAddr_r == `FORCE_OFS && wStrb_r[0]) begin
      convForce_r <= wData_r[`FORCE_CONV_ON];
      convSelRc_r <= wData_r[`FORCE_CONV_SEL];
    end else if (doWrite && awAddr_r == `INT_EN_OFS && wStrb_r[0]) begin
      failIntEn_r <= wData_r[`INT_FAIL_BIT];
    end
  end

  assign ctrlWrite = doWrite && awAddr_r == `CTRL_OFS;
  always_comb begin
    ctrlWord = 32'h0000_0000;
    ctrlWord[`SEL_LSB +: 3] = newSel_r;
    ctrlWord[`DIV_LSB +: 4] = newDiv_r;
    ctrlWord[`FRQ_LSB +: 4] = freq_r;
  end

  // Sample clock: low-frequency clock divided down, a toggle every half period.
  assign lfRise = lowFreqInternalClk && !lfPrev_r;
  assign extFall = !extClk && extPrev_r;
  assign sampleRise = lfRise && divCnt_r == HALF_LAST && !sampleClk_r;
  assign sampleFall = lfRise && divCnt_r == HALF_LAST && sampleClk_r;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lfPrev_r <= 1'b0;
      extPrev_r <= 1'b0;
    end else begin
      lfPrev_r <= lowFreqInternalClk;
      extPrev_r <= extClk;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      divCnt_r <= 16'h0000;
      sampleClk_r <= 1'b0;
    end else if (lfRise) begin
      if (divCnt_r == HALF_LAST) begin
        divCnt_r <= 16'h0000;
        sampleClk_r <= !sampleClk_r;
      end else begin
        divCnt_r <= divCnt_r + 16'h0001;
      end
    end
  end

  assign monActive = monitorEnableCfg && isExternal(curSel_r) && !failSafe_r;

  // A fall in the same cycle as the sample rise counts, so set beats clear.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      detLatch_r <= 1'b0;
    end else if (extFall) begin
      detLatch_r <= 1'b1;
    end else if (sampleRise) begin
      detLatch_r <= 1'b0;
    end
  end

  // Arming waits for a sample rise, so a partial first window never reports a failure.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      armed_r <= 1'b0;
    end else if (!monActive) begin
      armed_r <= 1'b0;
    end else if (sampleRise) begin
      armed_r <= 1'b1;
    end
  end

  assign failDet = monActive && armed_r && sampleFall && !detLatch_r && !extFall;

  // Clock selection, startup timer and the fail-safe condition.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      newSel_r <= `SEL_HF_INT;
      newDiv_r <= `DIV_RST;
      freq_r <= `FRQ_RST;
      curSel_r <= `SEL_HF_INT;
      curDiv_r <= `DIV_RST;
      failSafe_r <= 1'b0;
      ostState_r <= ST_IDLE;
      ostCnt_r <= 16'h0000;
    end else if (!started_r) begin
      newSel_r <= resetClkSelectCfg;
      curSel_r <= isExternal(resetClkSelectCfg) ? `SEL_HF_INT : resetClkSelectCfg;
      ostState_r <= isExternal(resetClkSelectCfg) ? ST_COUNT : ST_IDLE;
    end else if (failDet) begin
      curSel_r <= `SEL_HF_INT;
      failSafe_r <= 1'b1;
      ostState_r <= ST_IDLE;
    end else if (ctrlWrite) begin
      newSel_r <= wStrb_r[0] ? wData_r[`SEL_LSB +: 3] : newSel_r;
      newDiv_r <= wStrb_r[0] ? wData_r[`DIV_LSB +: 4] : newDiv_r;
      freq_r <= wStrb_r[1] ? wData_r[`FRQ_LSB +: 4] : freq_r;
      failSafe_r <= 1'b0;
      ostCnt_r <= 16'h0000;
      if (wStrb_r[0] && isExternal(wData_r[`SEL_LSB +: 3])) begin
        ostState_r <= ST_COUNT;
      end else begin
        ostState_r <= ST_IDLE;
        curSel_r <= wStrb_r[0] ? wData_r[`SEL_LSB +: 3] : curSel_r;
        curDiv_r <= wStrb_r[0] ? wData_r[`DIV_LSB +: 4] : curDiv_r;
      end
    end else begin
      if (sleepExec) begin
        failSafe_r <= 1'b0;
      end
      case (ostState_r)
        ST_IDLE: begin
          ostCnt_r <= 16'h0000;
        end
        ST_COUNT: begin
          if (extFall) begin
            if (ostCnt_r == OST_LAST) begin
              ostState_r <= ST_SWAP;
            end else begin
              ostCnt_r <= ostCnt_r + 16'h0001;
            end
          end
        end
        ST_SWAP: begin
          curSel_r <= newSel_r;
          curDiv_r <= newDiv_r;
          failSafe_r <= 1'b0;
          ostState_r <= ST_IDLE;
        end
        default: begin
          ostState_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Software clears the flag by writing one; a failure in the same cycle still sets it.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      failFlag_r <= 1'b0;
    end else if (failDet) begin
      failFlag_r <= 1'b1;
    end else if (doWrite && awAddr_r == `INT_CLR_OFS && wStrb_r[0] &&
                 wData_r[`INT_FAIL_BIT]) begin
      failFlag_r <= 1'b0;
    end
  end

  assign irq = failFlag_r && failIntEn_r;

  always_comb begin
    clkState.currentClkSelect = curSel_r;
    clkState.currentDivider = curDiv_r;
    clkState.hfFreqSelect = freq_r;
    clkState.failSafe = failSafe_r;
    clkState.startupBusy = ostState_r != ST_IDLE;
    clkState.lowFreqEnable = resetSel_r == `SEL_LF_INT || newSel_r == `SEL_LF_INT;
    clkState.converterRcEnable = convForce_r || convSelRc_r;
  end

endmodule : osc_tune_and_fail_safe_monitor

`default_nettype wire

// ### osc_tune_and_fail_safe_monitor_bench.sv
// Self-checking bench for the clock control block over its register bus.
// Assumes the block, package, constants header, checker and oscillator model.
`timescale 1ns/10ps
`include "osc_fail_monitor_regs.svh"
`default_nettype none

module osc_tune_and_fail_safe_monitor_bench
  import osc_fail_monitor_pkg::*;
;
  logic sys_clk = 1'h0;
  logic rst_b = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic sleepExec = 1'h0, monitorEnableCfg = 1'h1, extRun = 1'h0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, rdVal;
  logic [3:0] wstrb = 4'hf;
  logic [2:0] resetClkSelectCfg = 3'h6;
  logic [2:0] lfCnt = '0;
  logic awready, wready, bvalid, arready, rvalid, irq, extClk, lowFreqInternalClk;
  logic [1:0] bresp, rresp, rdResp;
  logic [5:0] oscTrimValue;
  logic [5:0] trims [2] = '{6'h1f, 6'h20};
  clkState_t clkState;
  int error_cnt = 0, compares = 0, cyc = 0;

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) lfCnt <= lfCnt + 3'h1;
  assign lowFreqInternalClk = lfCnt[2];

  // The startup count is shortened so each switch back takes only a few oscillator periods.
  osc_tune_and_fail_safe_monitor #(.OST_COUNT(4)) uut (
    .sys_clk, .rst_b, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .monitorEnableCfg, .resetClkSelectCfg, .sleepExec, .extClk,
    .lowFreqInternalClk, .oscTrimValue, .clkState, .irq);
  ext_osc_model #(.HALF(2)) osc (.sys_clk(sys_clk), .run(extRun), .extClk(extClk));

  task automatic wrap_up();
    if (error_cnt == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt = error_cnt + 1;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk

  // Handshakes are read right after the rising edge, before that edge's updates land.
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic dn;
    dn = 1'h0;
    if (w) begin
      awaddr <= 32'(a);
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
    end else begin
      araddr <= 32'(a);
      arvalid <= 1'h1;
      rready <= 1'h1;
    end
    while (!dn) begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (arvalid && arready) arvalid <= 1'h0;
      if (w ? bvalid : rvalid) begin
        dn = 1'h1;
        rdVal = rdata;
        rdResp = w ? bresp : rresp;
      end
    end
    bready <= 1'h0;
    rready <= 1'h0;
    @(posedge sys_clk);
  endtask : acc

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    acc(1'h0, a, 32'h0);
    chk(rdVal, e);
  endtask : rc

  task automatic pollStat(input int i, input logic v);
    for (int n = 0; n < 400; n++) begin
      acc(1'h0, `STAT_OFS, 32'h0);
      if (rdVal[i] === v) break;
    end
    chk(rdVal[i], v);
  endtask : pollStat

  initial begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'h1;
    @(posedge sys_clk);
    rc(`TRIM_OFS, 32'h0);
    rc(`STAT_OFS, 32'h0000_0006);
    foreach (trims[i]) begin
      acc(1'h1, `TRIM_OFS, 32'(trims[i]));
      chk(oscTrimValue, trims[i]);
      rc(`TRIM_OFS, 32'(trims[i]));
      rc(`STAT_OFS, 32'h0000_0006);
    end
    acc(1'h1, `CTRL_OFS, 32'h0000_0005);
    rc(`STAT_OFS, 32'h0000_0405);
    acc(1'h1, `CTRL_OFS, 32'h0000_0006);
    rc(`STAT_OFS, 32'h0000_0006);
    for (int f = 3; f >= 0; f--) begin
      acc(1'h1, `FORCE_OFS, 32'(f));
      chk(clkState.converterRcEnable, f != 0);
    end
    acc(1'h1, 8'h40, 32'h1);
    chk(rdResp, `RESP_SLVERR);
    rc(8'h40, 32'h0);
    chk(rdResp, `RESP_SLVERR);
    extRun <= 1'h1;
    acc(1'h1, `CTRL_OFS, 32'h0000_0a37);
    chk(clkState.startupBusy, 1'h1);
    chk(clkState.currentClkSelect, 3'h6);
    pollStat(`ST_TIMER, 1'h0);
    rc(`STAT_OFS, 32'h0000_0037);
    repeat (1000) @(posedge sys_clk);
    rc(`STAT_OFS, 32'h0000_0037);
    acc(1'h1, `INT_EN_OFS, 32'h1);
    extRun <= 1'h0;
    pollStat(`ST_FAILSAFE, 1'h1);
    rc(`STAT_OFS, 32'h0000_0136);
    rc(`CTRL_OFS, 32'h0000_0a37);
    chk(clkState.hfFreqSelect, 4'ha);
    rc(`INT_STAT_OFS, 32'h1);
    chk(irq, 1'h1);
    extRun <= 1'h1;
    repeat (600) @(posedge sys_clk);
    rc(`STAT_OFS, 32'h0000_0136);
    acc(1'h1, `INT_STAT_OFS, 32'h0);
    rc(`INT_STAT_OFS, 32'h1);
    acc(1'h1, `INT_CLR_OFS, 32'h1);
    chk(irq, 1'h0);
    rc(`INT_STAT_OFS, 32'h0);
    sleepExec <= 1'h1;
    @(posedge sys_clk);
    sleepExec <= 1'h0;
    rc(`STAT_OFS, 32'h0000_0036);
    acc(1'h1, `CTRL_OFS, 32'h0000_0034);
    pollStat(`ST_TIMER, 1'h0);
    rc(`STAT_OFS, 32'h0000_0034);
    acc(1'h1, `INT_EN_OFS, 32'h0);
    extRun <= 1'h0;
    pollStat(`ST_FAILSAFE, 1'h1);
    rc(`INT_STAT_OFS, 32'h1);
    chk(irq, 1'h0);
    acc(1'h1, `CTRL_OFS, 32'h0000_0026);
    rc(`STAT_OFS, 32'h0000_0026);
    monitorEnableCfg <= 1'h0;
    extRun <= 1'h1;
    acc(1'h1, `CTRL_OFS, 32'h0000_0032);
    pollStat(`ST_TIMER, 1'h0);
    extRun <= 1'h0;
    repeat (1500) @(posedge sys_clk);
    rc(`STAT_OFS, 32'h0000_0032);
    resetClkSelectCfg <= 3'h5;
    rst_b <= 1'h0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'h1;
    @(posedge sys_clk);
    rc(`STAT_OFS, 32'h0000_0405);
    rc(`TRIM_OFS, 32'h0);
    rc(`INT_STAT_OFS, 32'h0);
    wrap_up();
  end
endmodule : osc_tune_and_fail_safe_monitor_bench

`default_nettype wire

// ### osc_tune_and_fail_safe_monitor_properties.sv
// Assertions for the clock control block, bound to its top module.
// Assumes the package and the constants header are compiled first.
`timescale 1ns/10ps
`include "osc_fail_monitor_regs.svh"
`default_nettype none

module osc_fail_monitor_checker
  import osc_fail_monitor_pkg::*;
#(
  parameter int unsigned SAMPLE_DIV = 64
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_b,
  // Observed ports.
  input wire logic bvalid,
  input wire logic monitorEnableCfg,
  input wire logic sleepExec,
  input wire logic extClk,
  input wire logic lowFreqInternalClk,
  input wire logic [5:0] oscTrimValue,
  input wire clkState_t clkState,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  logic extPrev;
  logic lfPrev;
  int unsigned lfSinceFall;

  // Low-frequency rises since the external clock last fell; saturates so it never wraps.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      extPrev <= 1'h1;
      lfPrev <= 1'h0;
      lfSinceFall <= 0;
    end else begin
      extPrev <= extClk;
      lfPrev <= lowFreqInternalClk;
      if (extPrev && !extClk) begin
        lfSinceFall <= 0;
      end else if (lowFreqInternalClk && !lfPrev && lfSinceFall < 1000) begin
        lfSinceFall <= lfSinceFall + 1;
      end
    end
  end

  property p_trim;
    $changed(oscTrimValue) |-> $rose(bvalid);
  endproperty
  a_trim: assert property (p_trim) else $error("trim moved without a write");
  property p_conv;
    $changed(clkState.converterRcEnable) |-> $rose(bvalid);
  endproperty
  a_conv: assert property (p_conv) else $error("converter clock moved alone");
  property p_fail_sel;
    $rose(clkState.failSafe) |->
      clkState.currentClkSelect == `SEL_HF_INT && $stable(clkState.currentDivider);
  endproperty
  a_fail_sel: assert property (p_fail_sel) else $error("bad select on failure");
  property p_irq;
    $rose(irq) |-> $rose(bvalid) || $rose(clkState.failSafe);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt without cause");
  property p_quiet;
    $rose(clkState.failSafe) |-> $past(monitorEnableCfg) &&
      $past(clkState.currentClkSelect) inside {`SEL_EXT_PLL, `SEL_SECONDARY, `SEL_EXT};
  endproperty
  a_quiet: assert property (p_quiet) else $error("failure while inactive");
  property p_latency;
    $rose(clkState.failSafe) |-> lfSinceFall >= SAMPLE_DIV / 2 - 1;
  endproperty
  a_latency: assert property (p_latency) else $error("failure declared too early");
  property p_hold;
    clkState.startupBusy && $past(clkState.startupBusy) |-> $stable(clkState.currentClkSelect);
  endproperty
  a_hold: assert property (p_hold) else $error("select moved during startup");
  property p_swap;
    $fell(clkState.startupBusy) && !$rose(clkState.failSafe) && !$rose(bvalid) |->
      !clkState.failSafe && clkState.currentClkSelect != `SEL_HF_INT;
  endproperty
  a_swap: assert property (p_swap) else $error("startup end did not switch");
  property p_sleep;
    clkState.failSafe && sleepExec |=> !clkState.failSafe;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep kept fail state");
endmodule : osc_fail_monitor_checker

bind osc_tune_and_fail_safe_monitor osc_fail_monitor_checker #(.SAMPLE_DIV(SAMPLE_DIV)) chkr (
  .sys_clk(sys_clk), .rst_b(rst_b), .bvalid(bvalid), .monitorEnableCfg(monitorEnableCfg),
  .sleepExec(sleepExec), .extClk(extClk), .lowFreqInternalClk(lowFreqInternalClk),
  .oscTrimValue(oscTrimValue), .clkState(clkState), .irq(irq));

`default_nettype wire
